// File: lg_map.svh
`ifndef LG_MAP_SVH
`define LG_MAP_SVH
// Clock and time base
`define LG_CLK_NS        20
`define LG_MS_NS         1000000
// Buffer depth and rate codes
`define LG_DEPTH         7'h64
`define LG_RATE_EVERY    3'h0
`define LG_RATE_MANUAL   3'h6
// Store intervals in seconds for rate codes 1 to 5
`define LG_SEC_R1        12'h001
`define LG_SEC_R2        12'h00A
`define LG_SEC_R3        12'h03C
`define LG_SEC_R4        12'h258
`define LG_SEC_R5        12'h0E10
// Front panel timing in milliseconds
`define LG_DEB_MS        5'h14
`define LG_STEP_MS       12'h1F4
`define LG_FAST_MS       12'h064
`define LG_FAST_AFTER_MS 12'h07D0
`define LG_THIRD_MS      9'h14D
`define LG_SEC_MS        10'h3E8
`define LG_LOC_MS        10'h3E8
`define LG_FLASH_MS      8'hFA
// Register byte offsets
`define LG_A_CTRL        8'h00
`define LG_A_STATUS      8'h04
`define LG_A_IRQ_STAT    8'h08
`define LG_A_IRQ_MASK    8'h0C
`define LG_A_MIN         8'h10
`define LG_A_MAX         8'h14
`define LG_A_RD_IDX      8'h18
`define LG_A_RD_DATA     8'h1C
// Field positions and reset values
`define LG_CTRL_PANEL    0
`define LG_CTRL_RST      1'b1
`define LG_IRQ_STORED    0
`define LG_IRQ_FULL      1
`define LG_IRQ_STOPPED   2
`endif

// File: lg_pkg.sv
package lg_pkg;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SELECT = 2'b01,
      ST_LOG    = 2'b10,
      ST_LOC    = 2'b11
   } lg_state_t;
   typedef enum logic [2:0] {
      DK_LIVE = 3'b000,
      DK_RATE = 3'b001,
      DK_LOC  = 3'b010,
      DK_DATA = 3'b011,
      DK_HIGH = 3'b100,
      DK_LOW  = 3'b101
   } lg_disp_t;
   typedef logic [23:0] lg_rdg_t;
endpackage : lg_pkg

// File: lg_btn_if.sv
`timescale 1ns/1ps
interface lg_btn_if;
   logic        level;
   logic        press;
   logic        release_p;
   logic [11:0] held_ms;
   modport src (output level, press, release_p, held_ms);
   modport snk (input  level, press, release_p, held_ms);
endinterface : lg_btn_if

// File: lg_timebase.sv
`timescale 1ns/1ps
`include "lg_map.svh"
module lg_timebase import lg_pkg::*; #(
   parameter int MS_CYCLES = 50000
) (
   input  wire logic sys_clk_in,
   input  wire logic reset_in,
   output logic      ms_tick_out,
   output logic      third_tick_out,
   output logic      sec_tick_out
);
   logic [15:0] cyc_r;
   logic [8:0]  third_ms_r;
   logic [9:0]  sec_ms_r;
   wire         ms_end = (cyc_r == 16'(MS_CYCLES - 1));

   // Millisecond prescaler
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         cyc_r       <= 16'h0000;
         ms_tick_out <= 1'b0;
      end else begin
         cyc_r       <= ms_end ? 16'h0000 : cyc_r + 16'h0001;
         ms_tick_out <= ms_end;
      end
   end

   // Third-second and one-second enables
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         third_ms_r     <= 9'h000;
         sec_ms_r       <= 10'h000;
         third_tick_out <= 1'b0;
         sec_tick_out   <= 1'b0;
      end else begin
         third_tick_out <= 1'b0;
         sec_tick_out   <= 1'b0;
         if (ms_tick_out) begin
            third_tick_out <= (third_ms_r == `LG_THIRD_MS - 9'h001);
            sec_tick_out   <= (sec_ms_r == `LG_SEC_MS - 10'h001);
            third_ms_r <= (third_ms_r == `LG_THIRD_MS - 9'h001) ?
                          9'h000 : third_ms_r + 9'h001;
            sec_ms_r   <= (sec_ms_r == `LG_SEC_MS - 10'h001) ?
                          10'h000 : sec_ms_r + 10'h001;
         end
      end
   end
endmodule : lg_timebase

// File: lg_button.sv
`timescale 1ns/1ps
`include "lg_map.svh"
module lg_button import lg_pkg::*; (
   input  wire logic sys_clk_in,
   input  wire logic reset_in,
   input  wire logic pin_in,
   input  wire logic ms_tick_in,
   lg_btn_if.src     btn
);
   logic       sync1_r;
   logic       sync2_r;
   logic [4:0] deb_r;

   // Two-stage synchroniser
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
      end
   end

   // Debounce, edge pulses and hold time
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         deb_r         <= 5'h00;
         btn.level     <= 1'b0;
         btn.press     <= 1'b0;
         btn.release_p <= 1'b0;
         btn.held_ms   <= 12'h000;
      end else begin
         btn.press     <= 1'b0;
         btn.release_p <= 1'b0;
         if (sync2_r == btn.level) begin
            deb_r <= 5'h00;
         end else if (ms_tick_in) begin
            deb_r <= deb_r + 5'h01;
            if (deb_r == `LG_DEB_MS - 5'h01) begin
               deb_r         <= 5'h00;
               btn.level     <= sync2_r;
               btn.press     <= sync2_r;
               btn.release_p <= ~sync2_r;
            end
         end
         if (!btn.level) begin
            btn.held_ms <= 12'h000;
         end else if (ms_tick_in && btn.held_ms != 12'hFFF) begin
            btn.held_ms <= btn.held_ms + 12'h001;
         end
      end
   end
endmodule : lg_button

// File: lg_logger.sv
// Behaviour
// - Buffer of 100 readings plus min/max
// - Seven rate codes: every reading, five timed, plus manual
// - Min/max sampled three times per second
// - Hold store scrolls codes, release starts logging
// - Brief store press starts logging every reading
// - Manual press stores, shows location, returns live
// - Store press stops timed logging, data kept
// - Manual logging stops on recall plus store
// - Min/max track while active, freeze when stopped
// - Recall indicator flashes when buffer full
// - Recall shows last, high, low, then rest
// - Held recall scrolls faster, tap steps one
`timescale 1ns/1ps
`include "lg_map.svh"
module lg_logger import lg_pkg::*; #(
   parameter int MS_CYCLES = `LG_MS_NS / `LG_CLK_NS
) (
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   input  wire logic        store_clear_button_in,
   input  wire logic        recall_button_in,
   input  wire logic [23:0] reading_in,
   input  wire logic        reading_valid_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hwdata_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   output logic             irq_out,
   output logic             store_active_indicator_out,
   output logic             recall_indicator_out,
   output logic      [23:0] display_value_out,
   output logic      [2:0]  display_kind_out,
   output logic      [6:0]  display_index_out
);
   lg_btn_if   sc_if ();
   lg_btn_if   rc_if ();
   logic       ms_tick;
   logic       third_tick;
   logic       sec_tick;
   lg_state_t  state_r;
   lg_state_t  state_nxt;
   lg_rdg_t    mem [0:99];
   lg_rdg_t    last_r;
   lg_rdg_t    min_r;
   lg_rdg_t    max_r;
   logic       have_rd_r;
   logic       mm_valid_r;
   logic [6:0] count_r;
   logic [2:0] rate_r;
   logic [2:0] sel_rate_r;
   logic [11:0] scroll_ms_r;
   logic [11:0] sec_cnt_r;
   logic [9:0] loc_ms_r;
   logic       view_r;
   logic [6:0] step_r;
   logic [11:0] rep_ms_r;
   logic [7:0] flash_ms_r;
   logic       flash_r;
   logic       panel_en_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_mask_r;
   logic [6:0] rd_idx_r;
   logic       wr_pend_r;
   logic [7:0] wr_addr_r;

   // Store interval in seconds for a timed rate code
   function automatic logic [11:0] rate_secs(input logic [2:0] r);
      case (r)
         3'h1:    rate_secs = `LG_SEC_R1;
         3'h2:    rate_secs = `LG_SEC_R2;
         3'h3:    rate_secs = `LG_SEC_R3;
         3'h4:    rate_secs = `LG_SEC_R4;
         default: rate_secs = `LG_SEC_R5;
      endcase
   endfunction : rate_secs

   // Next recall step, wrapping after the oldest entry
   function automatic logic [6:0] next_step(input logic [6:0] s,
                                            input logic [6:0] cnt);
      logic [6:0] last;
      last = (cnt < 7'h02) ? 7'h02 : cnt + 7'h01;
      next_step = (s >= last) ? 7'h00 : s + 7'h01;
   endfunction : next_step

   lg_timebase #(.MS_CYCLES(MS_CYCLES)) u_tb (
      .sys_clk_in     (sys_clk_in),
      .reset_in       (reset_in),
      .ms_tick_out    (ms_tick),
      .third_tick_out (third_tick),
      .sec_tick_out   (sec_tick)
   );
   lg_button u_sc (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .pin_in     (store_clear_button_in),
      .ms_tick_in (ms_tick),
      .btn        (sc_if.src)
   );
   lg_button u_rc (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .pin_in     (recall_button_in),
      .ms_tick_in (ms_tick),
      .btn        (rc_if.src)
   );

   // Button events and logger decode
   wire logging   = (state_r == ST_LOG) || (state_r == ST_LOC);
   wire sc_press  = sc_if.press & panel_en_r;
   wire sc_rel    = sc_if.release_p;
   wire rc_press  = rc_if.press & panel_en_r;
   wire full      = (count_r == `LG_DEPTH);
   wire manual    = (rate_r == `LG_RATE_MANUAL);
   wire stop_evt  = logging && sc_press && (!manual || rc_if.level);
   wire trig_evt  = logging && sc_press && manual && !rc_if.level;
   wire start_evt = (state_r == ST_SELECT) && sc_rel;
   wire sec_due   = sec_tick && (sec_cnt_r == rate_secs(rate_r) - 12'h001);
   wire timed_due = (rate_r == `LG_RATE_EVERY) ? reading_valid_in : sec_due;
   // Stop wins over a store in the same cycle
   wire store_evt = logging && !full && !stop_evt &&
                    (manual ? trig_evt : timed_due);
   wire lg_rdg_t store_data = (rate_r == `LG_RATE_EVERY) ? reading_in
                                                          : last_r;
   wire scroll_end = ms_tick && (scroll_ms_r == `LG_STEP_MS - 12'h001);
   wire loc_end   = ms_tick && (loc_ms_r == `LG_LOC_MS - 10'h001);
   wire [11:0] rep_period = (rc_if.held_ms >= `LG_FAST_AFTER_MS) ?
                            `LG_FAST_MS : `LG_STEP_MS;
   wire rep_evt   = view_r && rc_if.level && ms_tick &&
                    (rep_ms_r >= rep_period - 12'h001);
   wire advance   = view_r && (rc_press || rep_evt);
   wire mm_sample = logging && have_rd_r && third_tick;
   wire [6:0] rcl_addr = (step_r == 7'h00) ? count_r - 7'h01
                                           : count_r + 7'h01 - step_r;

   // Logger state selection
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:   if (sc_press) state_nxt = ST_SELECT;
         ST_SELECT: if (sc_rel) state_nxt = ST_LOG;
         ST_LOG,
         ST_LOC: begin
            if (stop_evt) begin
               state_nxt = ST_IDLE;
            end else if (trig_evt) begin
               state_nxt = ST_LOC;
            end else if (state_r == ST_LOC && loc_end) begin
               state_nxt = ST_LOG;
            end
         end
      endcase
   end

   // State, rate choice and timers
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state_r     <= ST_IDLE;
         rate_r      <= `LG_RATE_EVERY;
         sel_rate_r  <= `LG_RATE_EVERY;
         scroll_ms_r <= 12'h000;
         sec_cnt_r   <= 12'h000;
         loc_ms_r    <= 10'h000;
      end else begin
         state_r <= state_nxt;
         if (state_r != ST_SELECT) begin
            sel_rate_r  <= `LG_RATE_EVERY;
            scroll_ms_r <= 12'h000;
         end else if (scroll_end) begin
            scroll_ms_r <= 12'h000;
            sel_rate_r  <= (sel_rate_r == `LG_RATE_MANUAL) ?
                           `LG_RATE_EVERY : sel_rate_r + 3'h1;
         end else if (ms_tick) begin
            scroll_ms_r <= scroll_ms_r + 12'h001;
         end
         if (start_evt) begin
            rate_r <= sel_rate_r;
         end
         if (start_evt || sec_due) begin
            sec_cnt_r <= 12'h000;
         end else if (sec_tick) begin
            sec_cnt_r <= sec_cnt_r + 12'h001;
         end
         loc_ms_r <= (state_r != ST_LOC || trig_evt) ? 10'h000 :
                     ms_tick ? loc_ms_r + 10'h001 : loc_ms_r;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (store_evt) begin
         mem[count_r] <= store_data;
      end
   end

   // Store pointer, latest reading and min/max
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         count_r    <= 7'h00;
         last_r     <= 24'h00_0000;
         have_rd_r  <= 1'b0;
         mm_valid_r <= 1'b0;
         min_r      <= 24'h00_0000;
         max_r      <= 24'h00_0000;
      end else begin
         if (reading_valid_in) begin
            last_r    <= reading_in;
            have_rd_r <= 1'b1;
         end
         if (start_evt) begin
            count_r <= 7'h00;
         end else if (store_evt) begin
            count_r <= count_r + 7'h01;
         end
         if (start_evt) begin
            mm_valid_r <= 1'b0;
         end else if (mm_sample) begin
            mm_valid_r <= 1'b1;
            if (!mm_valid_r || $signed(last_r) < $signed(min_r)) begin
               min_r <= last_r;
            end
            if (!mm_valid_r || $signed(last_r) > $signed(max_r)) begin
               max_r <= last_r;
            end
         end
      end
   end

   // Recall view stepping
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         view_r   <= 1'b0;
         step_r   <= 7'h00;
         rep_ms_r <= 12'h000;
      end else begin
         // newest first, then high and low
         // tap steps one, hold repeats faster
         if (sc_press) begin
            view_r <= 1'b0;
         end else if (rc_press && !view_r && state_r != ST_SELECT) begin
            view_r <= 1'b1;
            step_r <= 7'h00;
         end else if (advance) begin
            step_r <= next_step(step_r, count_r);
         end
         rep_ms_r <= (!rc_if.level || advance) ? 12'h000 :
                     ms_tick ? rep_ms_r + 12'h001 : rep_ms_r;
      end
   end

   // Display and indicators
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         display_value_out          <= 24'h00_0000;
         display_kind_out           <= DK_LIVE;
         display_index_out          <= 7'h00;
         store_active_indicator_out <= 1'b0;
         recall_indicator_out       <= 1'b0;
         flash_ms_r                 <= 8'h00;
         flash_r                    <= 1'b0;
      end else begin
         display_value_out <= last_r;
         display_index_out <= count_r;
         display_kind_out  <= DK_LIVE;
         if (state_r == ST_SELECT) begin
            display_kind_out  <= DK_RATE;
            display_index_out <= {4'h0, sel_rate_r};
         end else if (state_r == ST_LOC) begin
            display_kind_out <= DK_LOC;
         end else if (view_r && step_r == 7'h01) begin
            display_kind_out <= DK_HIGH;
            display_value_out <= max_r;
         end else if (view_r && step_r == 7'h02) begin
            display_kind_out <= DK_LOW;
            display_value_out <= min_r;
         end else if (view_r) begin
            display_kind_out  <= DK_DATA;
            display_index_out <= rcl_addr;
            display_value_out <= (count_r == 7'h00) ? 24'h00_0000
                                                    : mem[rcl_addr];
         end
         store_active_indicator_out <= logging;
         if (ms_tick) begin
            flash_ms_r <= (flash_ms_r == `LG_FLASH_MS - 8'h01) ?
                          8'h00 : flash_ms_r + 8'h01;
            if (flash_ms_r == `LG_FLASH_MS - 8'h01) begin
               flash_r <= ~flash_r;
            end
         end
         recall_indicator_out <= full & flash_r;
      end
   end

   // Bus decode
   wire        addr_ok  = hsel_in && hready_in && htrans_in[1];
   wire [7:0]  a_addr   = haddr_in[7:0];
   wire [2:0]  ev_set   = {stop_evt, store_evt && count_r ==
                           `LG_DEPTH - 7'h01, store_evt};
   wire [2:0]  w1c      = (wr_pend_r && wr_addr_r == `LG_A_IRQ_STAT) ?
                          hwdata_in[2:0] : 3'h0;
   wire [31:0] rd_mux   =
      (a_addr == `LG_A_CTRL)     ? {31'h0000_0000, panel_en_r} :
      (a_addr == `LG_A_STATUS)   ? {17'h0_0000, count_r, 3'h0, rate_r,
                                    full, logging} :
      (a_addr == `LG_A_IRQ_STAT) ? {29'h0000_0000, irq_stat_r} :
      (a_addr == `LG_A_IRQ_MASK) ? {29'h0000_0000, irq_mask_r} :
      (a_addr == `LG_A_MIN)      ? {8'h00, min_r} :
      (a_addr == `LG_A_MAX)      ? {8'h00, max_r} :
      (a_addr == `LG_A_RD_IDX)   ? {25'h000_0000, rd_idx_r} :
      (a_addr == `LG_A_RD_DATA && rd_idx_r < `LG_DEPTH) ?
                                   {8'h00, mem[rd_idx_r]} : 32'h0000_0000;

   // Zero-wait slave, read data captured in address phase
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         hrdata_out    <= 32'h0000_0000;
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
         wr_pend_r     <= 1'b0;
         wr_addr_r     <= 8'h00;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
         wr_pend_r     <= addr_ok && hwrite_in;
         wr_addr_r     <= a_addr;
         if (addr_ok && !hwrite_in) begin
            hrdata_out <= rd_mux;
         end
      end
   end

   // Registers and sticky interrupt status, set wins
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         panel_en_r <= `LG_CTRL_RST;
         irq_mask_r <= 3'h0;
         rd_idx_r   <= 7'h00;
         irq_stat_r <= 3'h0;
         irq_out    <= 1'b0;
      end else begin
         if (wr_pend_r && wr_addr_r == `LG_A_CTRL) begin
            panel_en_r <= hwdata_in[`LG_CTRL_PANEL];
         end
         if (wr_pend_r && wr_addr_r == `LG_A_IRQ_MASK) begin
            irq_mask_r <= hwdata_in[2:0];
         end
         if (wr_pend_r && wr_addr_r == `LG_A_RD_IDX) begin
            rd_idx_r <= hwdata_in[6:0];
         end
         irq_stat_r <= (irq_stat_r & ~w1c) | ev_set;
         irq_out    <= |(irq_stat_r & irq_mask_r);
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   sequence s_release_start;
      (state_r == ST_SELECT) && sc_rel;
   endsequence
   sequence s_logging_on;
      (state_r == ST_LOG) ##1 store_active_indicator_out;
   endsequence

   property p_depth;
      count_r <= `LG_DEPTH;
   endproperty
   a_depth: assert property (p_depth)
      else $error("store count beyond buffer depth");
   property p_rate1;
      (state_r == ST_LOG) && rate_r == 3'h1 && sec_tick && !full
         |-> store_evt;
   endproperty
   a_rate1: assert property (p_rate1)
      else $error("one per second store missed");
   property p_third;
      !$past(third_tick) |-> $stable(min_r) && $stable(max_r);
   endproperty
   a_third: assert property (p_third)
      else $error("min/max moved off the third-second tick");
   property p_select;
      s_release_start |=> (rate_r == $past(sel_rate_r)) and s_logging_on;
   endproperty
   a_select: assert property (p_select)
      else $error("release did not start logging at shown rate");
   property p_brief;
      (state_r == ST_IDLE) && sc_press |=>
         (state_r == ST_SELECT) && sel_rate_r == `LG_RATE_EVERY;
   endproperty
   a_brief: assert property (p_brief)
      else $error("store press from idle did not open selection");
   property p_trig;
      trig_evt && !full |=>
         count_r == $past(count_r) + 7'h01 && state_r == ST_LOC;
   endproperty
   a_trig: assert property (p_trig)
      else $error("manual trigger did not store and show location");
   property p_stop;
      stop_evt |=> (state_r == ST_IDLE) && $stable(count_r);
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop press did not end logging with data kept");
   property p_manual;
      (state_r == ST_LOG) && manual && sc_press && !rc_if.level
         |=> state_r != ST_IDLE;
   endproperty
   a_manual: assert property (p_manual)
      else $error("single store press ended manual logging");
   property p_frozen;
      (state_r == ST_IDLE) && $past(state_r == ST_IDLE)
         |-> $stable(min_r) && $stable(max_r);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("min/max updated while logger off");
   property p_flash;
      recall_indicator_out |-> $past(full);
   endproperty
   a_flash: assert property (p_flash)
      else $error("recall indicator flashing before buffer full");
   property p_order;
      advance && step_r == 7'h00 && !sc_press |=> step_r == 7'h01;
   endproperty
   a_order: assert property (p_order)
      else $error("high reading not shown after newest");
   property p_step;
      advance && !sc_press |=>
         step_r == next_step($past(step_r), $past(count_r));
   endproperty
   a_step: assert property (p_step)
      else $error("recall step did not advance by one");
   property p_full;
      full && state_r != ST_SELECT |=> count_r == `LG_DEPTH;
   endproperty
   a_full: assert property (p_full)
      else $error("store pointer moved after buffer full");
endmodule : lg_logger

// File: lg_panel_model.sv
`timescale 1ns/1ps
module lg_panel_model #(
   parameter int MSC = 10
) (
   input  wire logic  sys_clk_in,
   output logic       store_pin_out,
   output logic       recall_pin_out,
   output logic[23:0] reading_out,
   output logic       reading_valid_out
);
   // Panel idle at start
   initial begin
      store_pin_out = 1'b0;
      recall_pin_out = 1'b0;
      reading_out = 24'h00_0000;
      reading_valid_out = 1'b0;
   end
   // Hold store for ms, then let the debounce settle
   task automatic press_store(input int ms);
      store_pin_out <= 1'b1;
      repeat (ms * MSC) @(posedge sys_clk_in);
      store_pin_out <= 1'b0;
      repeat (40 * MSC) @(posedge sys_clk_in);
   endtask : press_store
   // Recall level, then settle
   task automatic set_recall(input logic v);
      recall_pin_out <= v;
      repeat (40 * MSC) @(posedge sys_clk_in);
   endtask : set_recall
   // One reading pulse; data scrambled outside it
   task automatic send(input logic [23:0] v);
      reading_out <= v;
      reading_valid_out <= 1'b1;
      @(posedge sys_clk_in);
      reading_valid_out <= 1'b0;
      reading_out <= ~v;
      @(posedge sys_clk_in);
   endtask : send
endmodule : lg_panel_model

// File: test_reading_logger_min_max.sv
`timescale 1ns/1ps
`include "lg_map.svh"
module test_reading_logger_min_max import lg_pkg::*;;
   logic        sys_clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        hsel_in = 1'b0, hwrite_in = 1'b0, rd_ph = 1'b0;
   logic [1:0]  htrans_in = 2'b00;
   logic [2:0]  hsize_in = 3'h2;
   logic [31:0] haddr_in = 32'h0000_0000, hwdata_in = 32'h0000_0000;
   logic [31:0] hrdata_out, v;
   logic [23:0] first_v, dv;
   logic        hreadyout_out, irq_out, hresp_out, sa_ind, rcl_ind;
   logic [2:0]  display_kind_out;
   logic [6:0]  display_index_out;
   int          num_errors = 0, n_tests = 0, seed = 60093;
   logic [31:0] exp_q[$];
   wire         st_pin, rc_pin, rv;
   wire  [23:0] rdg;
   lg_logger #(.MS_CYCLES(10)) dut_u (.sys_clk_in, .reset_in,
      .store_clear_button_in(st_pin), .recall_button_in(rc_pin),
      .reading_in(rdg), .reading_valid_in(rv), .hsel_in, .haddr_in,
      .htrans_in, .hwrite_in, .hsize_in, .hready_in(hreadyout_out),
      .hwdata_in, .hrdata_out, .hreadyout_out, .hresp_out, .irq_out,
      .store_active_indicator_out(sa_ind), .recall_indicator_out(rcl_ind),
      .display_value_out(dv), .display_kind_out, .display_index_out);
   lg_panel_model #(.MSC(10)) pm (.sys_clk_in, .store_pin_out(st_pin),
      .recall_pin_out(rc_pin), .reading_out(rdg), .reading_valid_out(rv));
   always #10 sys_clk_in = ~sys_clk_in;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Single AHB transfer, waits on ready in both phases
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel_in <= 1'b1;
      htrans_in <= 2'b10;
      hwrite_in <= w;
      haddr_in <= {24'h00_0000, a};
      @(posedge sys_clk_in);
      while (hreadyout_out !== 1'b1) @(posedge sys_clk_in);
      hsel_in <= 1'b0;
      htrans_in <= 2'b00;
      hwdata_in <= d;
      @(posedge sys_clk_in);
      while (hreadyout_out !== 1'b1) @(posedge sys_clk_in);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
   endtask : rd
   // Read data against oldest note
   always @(posedge sys_clk_in) begin
      if (rd_ph && hreadyout_out === 1'b1) begin
         chk(hrdata_out, exp_q.pop_front());
         chk(hresp_out, 1'b0);
      end
      if (hreadyout_out === 1'b1) rd_ph <= hsel_in & htrans_in[1] & ~hwrite_in;
   end
   task automatic wrap_up;
      if (num_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   // Hang guard
   initial begin
      repeat (90000) @(posedge sys_clk_in);
      num_errors++;
      wrap_up();
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      @(posedge sys_clk_in);
      rd(8'h40, 32'h0000_0000);
      bus(1'b1, `LG_A_IRQ_MASK, 32'h0000_0007);
      pm.press_store(50);
      rd(`LG_A_STATUS, 32'h0000_0001);
      for (int i = 0; i < 5; i++) begin
         v = $random(seed);
         if (i == 0) first_v = v[23:0];
         pm.send(v[23:0]);
      end
      rd(`LG_A_STATUS, 32'h0000_0501);
      @(negedge sys_clk_in);
      chk(irq_out, 1'b1);
      chk(sa_ind, 1'b1);
      @(posedge sys_clk_in);
      bus(1'b1, `LG_A_IRQ_STAT, 32'h0000_0007);
      repeat (3) @(negedge sys_clk_in);
      chk(irq_out, 1'b0);
      @(posedge sys_clk_in);
      // Fill the buffer and offer a few more
      for (int i = 0; i < 100; i++) begin
         v = $random(seed);
         pm.send(v[23:0]);
      end
      rd(`LG_A_STATUS, 32'h0000_6403);
      for (int i = 0; i < 6000 && rcl_ind !== 1'b1; i++) begin
         @(negedge sys_clk_in);
      end
      chk(rcl_ind, 1'b1);
      @(posedge sys_clk_in);
      bus(1'b1, `LG_A_RD_IDX, 32'h0000_0000);
      rd(`LG_A_RD_DATA, {8'h00, first_v});
      pm.press_store(50);
      rd(`LG_A_STATUS, 32'h0000_6402);
      rd(`LG_A_IRQ_STAT, 32'h0000_0007);
      pm.press_store(3200);
      rd(`LG_A_STATUS, 32'h0000_0019);
      v = $random(seed);
      pm.send(v[23:0]);
      pm.press_store(50);
      @(negedge sys_clk_in);
      chk(display_kind_out, DK_LOC);
      chk(display_index_out, 7'h01);
      chk(dv, v[23:0]);
      chk(sa_ind, 1'b1);
      @(posedge sys_clk_in);
      rd(`LG_A_STATUS, 32'h0000_0119);
      pm.set_recall(1'b1);
      pm.press_store(50);
      pm.set_recall(1'b0);
      rd(`LG_A_STATUS, 32'h0000_0118);
      // One per second rate: first store on a second tick
      bus(1'b1, `LG_A_IRQ_STAT, 32'h0000_0007);
      pm.press_store(700);
      for (int i = 0; i < 12000 && irq_out !== 1'b1; i++) begin
         @(negedge sys_clk_in);
      end
      chk(sa_ind, 1'b1);
      @(posedge sys_clk_in);
      rd(`LG_A_STATUS, 32'h0000_0105);
      repeat (3) @(posedge sys_clk_in);
      wrap_up();
   end
endmodule : test_reading_logger_min_max
